// ===== src/pwm_protect_pkg.sv
// Constants, register map and field layout for the PWM output protection block.
// Assumes a 32-bit APB slave where each register index maps to byte address 4 * index.
package pwm_protect_pkg;
  localparam int NUM_CH_DEF = 6;
  localparam int DEBOUNCE_CYCLES = 8;
  localparam int REG_W = 8;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_RUN_CONTROL = 10'h0D7;
  localparam logic [9:0] IDX_MASK_ENABLE = 10'h0D8;
  localparam logic [9:0] IDX_MASK_LEVEL = 10'h0D9;
  localparam logic [9:0] IDX_POLARITY = 10'h0DA;
  localparam logic [9:0] IDX_BRAKE_DATA = 10'h0DB;
  localparam logic [9:0] IDX_WAVE_CONFIG = 10'h0DC;
  localparam logic [9:0] IDX_POINT_CONFIG = 10'h0DD;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0DE;
  localparam int RUN_BIT = 7;
  localparam int LOAD_BIT = 6;
  localparam int PFLAG_BIT = 5;
  localparam int CLEAR_BIT = 4;
  localparam int BRAKE_FLAG_BIT = 7;
  localparam int BRAKE_EDGE_BIT = 6;
  localparam int BRAKE_IN_EN_BIT = 3;
  localparam int CENTER_TYPE_BIT = 4;
  localparam int BRAKE_IRQ_EN_BIT = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int TYP_LSB = 4;
  localparam int TYP_W = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef enum logic [1:0] {
    POINT_RISE,
    POINT_FALL,
    POINT_CENTER,
    POINT_END
  } point_type_t;
endpackage : pwm_protect_pkg

// ===== src/brake_debounce.sv
// Three-stage synchroniser and stability filter for the external fault brake pin.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
module brake_debounce #(
  parameter int STABLE_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_async,
  output logic level
);
  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [CNT_W-1:0] count;
    logic level;
  } deb_state_t;

  deb_state_t st_reg;
  deb_state_t st_next;

  if (STABLE_CYCLES < 2) begin : g_bad_len
    $error("brake_debounce needs at least two stable cycles");
  end

  // The level moves only after the synchronised pin differs from it for the whole window.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if ((st_reg.s2 == st_reg.s3) && (st_reg.s3 != st_reg.level)) begin
      if (st_reg.count == CNT_LAST) begin
        st_next.level = st_reg.s3;
        st_next.count = '0;
      end else begin
        st_next.count = st_reg.count + CNT_W'(1);
      end
    end else begin
      st_next.count = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;

  a_debounce_window: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(st_reg.level) |-> $past(st_reg.s3, STABLE_CYCLES) == st_reg.level)
    else $error("debounced level moved without a full stable window");
endmodule : brake_debounce

// ===== src/pwm_output_protect_control.sv
// Output stage of a six-channel PWM unit: masking, fault brake, polarity, flags and run control.
// Assumes generator signals and counter point pulses arrive on pclk; the brake pin is async.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module pwm_output_protect_control
  import pwm_protect_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] gen_signal,
  input wire logic period_complete,
  input wire logic counter_center_point,
  input wire logic counter_end_point,
  input wire logic fault_brake_input,
  input wire logic adc_compare_event,
  output logic [NUM_CH-1:0] pwm_out,
  output logic generator_run,
  output logic counter_reset,
  output logic buffer_reload,
  output logic period_irq,
  output logic brake_irq
);
  if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_ch
    $error("channel count must be 1 to 6 to fit the byte registers");
  end

  typedef struct packed {
    logic run;
    logic load_pend;
    logic period_flag;
    logic clr_pend;
    logic [NUM_CH-1:0] mask_en;
    logic [NUM_CH-1:0] mask_lvl;
    logic [NUM_CH-1:0] polarity;
    logic [NUM_CH-1:0] brake_data;
    logic brake_edge_sel;
    logic brake_flag;
    logic brake_in_en;
    logic center_type;
    logic [SEL_W-1:0] int_sel;
    logic [TYP_W-1:0] int_typ;
    logic brake_irq_en;
    logic brake_state;
    logic brake_level_q;
    logic [NUM_CH-1:0] gen_q;
    logic [NUM_CH-1:0] out;
    logic cnt_reset;
    logic reload;
    logic p_irq;
    logic b_irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;
  logic brake_level;
  logic [9:0] idx;
  logic wr_en;
  logic run_wr;
  logic run_set;
  logic load_set;
  logic clr_set;
  logic pin_event;
  logic brake_event;
  logic point_hit;
  logic sel_valid;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] rbyte;
  logic mapped;

  brake_debounce #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(fault_brake_input),
    .level(brake_level)
  );

  always_comb begin
    idx = paddr[ADDR_W-1:2];
    wbyte = pwdata[REG_W-1:0];
    wr_en = psel && penable && pready && pwrite;
    run_wr = wr_en && (idx == IDX_RUN_CONTROL);
    run_set = run_wr && wbyte[RUN_BIT];
    load_set = run_wr && wbyte[LOAD_BIT];
    clr_set = run_wr && wbyte[CLEAR_BIT];
    // Rising edge when the select bit is one, falling edge when it is zero.
    pin_event = st_reg.brake_in_en &&
      (brake_level != st_reg.brake_level_q) && (brake_level == st_reg.brake_edge_sel);
    brake_event = pin_event || adc_compare_event;
    sel_valid = int'(st_reg.int_sel) < NUM_CH;
    point_hit = 1'b0;
    if (sel_valid) begin
      case (point_type_t'(st_reg.int_typ))
        POINT_RISE: point_hit = gen_signal[st_reg.int_sel] && !st_reg.gen_q[st_reg.int_sel];
        POINT_FALL: point_hit = !gen_signal[st_reg.int_sel] && st_reg.gen_q[st_reg.int_sel];
        POINT_CENTER: point_hit = st_reg.center_type && counter_center_point;
        POINT_END: point_hit = st_reg.center_type && counter_end_point;
        default: point_hit = 1'b0;
      endcase
    end
    mapped = 1'b1;
    rbyte = RESET_BYTE;
    case (idx)
      IDX_RUN_CONTROL: begin
        rbyte[RUN_BIT] = st_reg.run;
        rbyte[LOAD_BIT] = st_reg.load_pend;
        rbyte[PFLAG_BIT] = st_reg.period_flag;
        rbyte[CLEAR_BIT] = st_reg.clr_pend;
      end
      IDX_MASK_ENABLE: rbyte[NUM_CH-1:0] = st_reg.mask_en;
      IDX_MASK_LEVEL: rbyte[NUM_CH-1:0] = st_reg.mask_lvl;
      IDX_POLARITY: rbyte[NUM_CH-1:0] = st_reg.polarity;
      IDX_BRAKE_DATA: begin
        rbyte[NUM_CH-1:0] = st_reg.brake_data;
        rbyte[BRAKE_EDGE_BIT] = st_reg.brake_edge_sel;
        rbyte[BRAKE_FLAG_BIT] = st_reg.brake_flag;
      end
      IDX_WAVE_CONFIG: begin
        rbyte[BRAKE_IN_EN_BIT] = st_reg.brake_in_en;
        rbyte[CENTER_TYPE_BIT] = st_reg.center_type;
      end
      IDX_POINT_CONFIG: begin
        rbyte[SEL_LSB +: SEL_W] = st_reg.int_sel;
        rbyte[TYP_LSB +: TYP_W] = st_reg.int_typ;
      end
      IDX_IRQ_ENABLE: rbyte[BRAKE_IRQ_EN_BIT] = st_reg.brake_irq_en;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.brake_level_q = brake_level;
    st_next.gen_q = gen_signal;
    st_next.cnt_reset = 1'b0;
    st_next.reload = 1'b0;
    // Zero-wait slave: read data and ready are loaded in the setup cycle.
    st_next.ready = psel && !penable;
    st_next.rdata = '0;
    st_next.slverr = 1'b0;
    if (psel && !penable) begin
      st_next.rdata = {{(32 - REG_W){1'b0}}, rbyte};
      st_next.slverr = !mapped;
    end
    if (wr_en) begin
      case (idx)
        IDX_RUN_CONTROL: begin
          st_next.run = wbyte[RUN_BIT];
          // Flag bits clear on a written zero; a written one leaves them alone.
          if (!wbyte[PFLAG_BIT]) begin
            st_next.period_flag = 1'b0;
          end
        end
        IDX_MASK_ENABLE: st_next.mask_en = wbyte[NUM_CH-1:0];
        IDX_MASK_LEVEL: st_next.mask_lvl = wbyte[NUM_CH-1:0];
        IDX_POLARITY: st_next.polarity = wbyte[NUM_CH-1:0];
        IDX_BRAKE_DATA: begin
          st_next.brake_data = wbyte[NUM_CH-1:0];
          st_next.brake_edge_sel = wbyte[BRAKE_EDGE_BIT];
          if (!wbyte[BRAKE_FLAG_BIT]) begin
            st_next.brake_flag = 1'b0;
          end
        end
        IDX_WAVE_CONFIG: begin
          st_next.brake_in_en = wbyte[BRAKE_IN_EN_BIT];
          st_next.center_type = wbyte[CENTER_TYPE_BIT];
        end
        IDX_POINT_CONFIG: begin
          st_next.int_sel = wbyte[SEL_LSB +: SEL_W];
          st_next.int_typ = wbyte[TYP_LSB +: TYP_W];
        end
        IDX_IRQ_ENABLE: st_next.brake_irq_en = wbyte[BRAKE_IRQ_EN_BIT];
        default: st_next.run = st_reg.run;
      endcase
    end
    // A pending reload completes at period end; a new request in that cycle stays pending.
    if (st_reg.load_pend && period_complete) begin
      st_next.load_pend = 1'b0;
      st_next.reload = 1'b1;
    end
    if (load_set) begin
      st_next.load_pend = 1'b1;
    end
    if (st_reg.clr_pend) begin
      st_next.clr_pend = 1'b0;
      st_next.cnt_reset = 1'b1;
    end
    if (clr_set) begin
      st_next.clr_pend = 1'b1;
    end
    // Writing run high releases the brake; the flag alone never does.
    if (run_set) begin
      st_next.brake_state = 1'b0;
    end
    if (point_hit) begin
      st_next.period_flag = 1'b1;
    end
    // A brake event in the same cycle as a run write wins, keeping the outputs safe.
    if (brake_event) begin
      st_next.brake_state = 1'b1;
      st_next.run = 1'b0;
      st_next.cnt_reset = 1'b1;
      st_next.brake_flag = 1'b1;
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (st_reg.brake_state) begin
        st_next.out[ch] = st_reg.brake_data[ch] ^ st_reg.polarity[ch];
      end else if (st_reg.mask_en[ch]) begin
        st_next.out[ch] = st_reg.mask_lvl[ch] ^ st_reg.polarity[ch];
      end else begin
        st_next.out[ch] = (st_reg.run && gen_signal[ch]) ^ st_reg.polarity[ch];
      end
    end
    st_next.p_irq = st_next.period_flag;
    st_next.b_irq = st_next.brake_flag && st_next.brake_irq_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.slverr;
  assign pwm_out = st_reg.out;
  assign generator_run = st_reg.run;
  assign counter_reset = st_reg.cnt_reset;
  assign buffer_reload = st_reg.reload;
  assign period_irq = st_reg.p_irq;
  assign brake_irq = st_reg.b_irq;

  a_brake_run_clear: assert property (@(posedge pclk) disable iff (!presetn)
    brake_event |=> !generator_run && st_reg.brake_state)
    else $error("brake event did not stop the generator");

  a_brake_cnt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    brake_event |=> counter_reset ##1
      ($past(brake_event) || $past(st_reg.clr_pend) || !counter_reset))
    else $error("brake event did not pulse the counter reset");

  a_brake_flag_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (brake_event && st_reg.brake_irq_en && !wr_en) |=> ##1 brake_irq)
    else $error("enabled brake flag did not raise the interrupt");

  a_brake_out_data: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.brake_state |=> pwm_out == ($past(st_reg.brake_data) ^ $past(st_reg.polarity)))
    else $error("brake state did not drive the brake data");

  a_brake_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.brake_state && !run_set) |=> st_reg.brake_state)
    else $error("brake state released without a run write");

  a_pin_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_reg.brake_in_en && !adc_compare_event && !st_reg.brake_state) |=> !st_reg.brake_state)
    else $error("brake fired while the pin was disabled");

  a_run_release: assert property (@(posedge pclk) disable iff (!presetn)
    (run_set && !brake_event) |=> generator_run && !st_reg.brake_state)
    else $error("run write did not release the brake");

  a_mask_level: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_reg.brake_state && st_reg.mask_en[0]) |=>
      pwm_out[0] == ($past(st_reg.mask_lvl[0]) ^ $past(st_reg.polarity[0])))
    else $error("masked channel did not show its polarity-adjusted level");

  a_reload_done: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.load_pend && period_complete && !load_set) |=> !st_reg.load_pend && buffer_reload)
    else $error("reload did not complete at period end");

  a_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    clr_set |=> st_reg.clr_pend ##1 counter_reset)
    else $error("counter clear request did not reset the counter");

  a_edge_only: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_reg.center_type && st_reg.int_typ[1] && !st_reg.period_flag) |=> !st_reg.period_flag)
    else $error("center or end point flagged in edge-aligned type");

  a_brake_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    brake_event |=> st_reg.brake_flag)
    else $error("brake event did not set the brake flag");

  a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    point_hit |=> st_reg.period_flag)
    else $error("selected point did not set the period flag");

  a_load_pending: assert property (@(posedge pclk) disable iff (!presetn)
    load_set |=> st_reg.load_pend)
    else $error("reload request was not held pending");

  a_polarity_out: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_reg.brake_state && !st_reg.mask_en[0]) |=>
      pwm_out[0] == ($past(st_reg.run && gen_signal[0]) ^ $past(st_reg.polarity[0])))
    else $error("unmasked channel did not show its polarity-adjusted signal");

  a_brake_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    brake_irq |-> (st_reg.brake_flag && st_reg.brake_irq_en))
    else $error("brake interrupt raised without an enabled flag");

  a_period_irq_flag: assert property (@(posedge pclk) disable iff (!presetn)
    period_irq == st_reg.period_flag)
    else $error("period interrupt does not follow the period flag");

  a_clear_self: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.clr_pend && !clr_set) |=> !st_reg.clr_pend)
    else $error("counter clear bit did not clear itself");
endmodule : pwm_output_protect_control

// ===== sim/brake_pin_model.sv
// Behavioural fault source standing on the brake pin of the output stage.
// Assumes the pin idles low through a pull-down and pulses are timed in pclk cycles.
`timescale 1ns/1ps
module brake_pin_model (
  input wire logic pclk,
  output logic fault_brake_input
);
  initial fault_brake_input = 1'b0;
  // Asserts a fault for the given cycles, then releases the pin to its pull-down.
  task automatic hold(input int cycles);
    @(posedge pclk);
    fault_brake_input <= 1'b1;
    repeat (cycles) @(posedge pclk);
    fault_brake_input <= 1'b0;
  endtask : hold
endmodule : brake_pin_model

// ===== sim/tb_pwm_output_protect_control.sv
// Self-checking bench for the PWM output protection block.
// Assumes the design package and an external fault source model on the brake pin.
`timescale 1ns/1ps
module tb_pwm_output_protect_control;
  import pwm_protect_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] gen_signal, pwm_out;
  logic [7:0] rd;
  logic period_complete, counter_center_point, counter_end_point, adc_compare_event;
  logic fault_brake_input, generator_run, counter_reset, buffer_reload, period_irq, brake_irq;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_clr = 0;
  int n_reload = 0;

  pwm_output_protect_control #(.NUM_CH(6)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gen_signal(gen_signal), .period_complete(period_complete),
    .counter_center_point(counter_center_point), .counter_end_point(counter_end_point),
    .fault_brake_input(fault_brake_input), .adc_compare_event(adc_compare_event),
    .pwm_out(pwm_out), .generator_run(generator_run), .counter_reset(counter_reset),
    .buffer_reload(buffer_reload), .period_irq(period_irq), .brake_irq(brake_irq)
  );
  brake_pin_model pin (.pclk(pclk), .fault_brake_input(fault_brake_input));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts one-cycle pulses and cuts a hang short.
  always @(posedge pclk) begin
    cycles++;
    if (counter_reset === 1'b1) n_clr++;
    if (buffer_reload === 1'b1) n_reload++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check({err, rd}, {1'b0, exp});
  endtask : rdc

  task automatic t_reset;
    for (int i = 0; i < 8; i++) rdc(IDX_RUN_CONTROL + 10'(i), RESET_BYTE);
    apb(1'b0, 10'h0DF, 8'h00);
    check({err, rd}, 9'h100);
  endtask : t_reset

  task automatic t_mask;
    gen_signal <= 6'h2A;
    wr(IDX_RUN_CONTROL, 8'h80);
    wr(IDX_MASK_ENABLE, 8'h03);
    wr(IDX_MASK_LEVEL, 8'h01);
    wr(IDX_POLARITY, 8'h05);
    tick(3);
    check(pwm_out, ((6'h2A & ~6'h03) | 6'h01) ^ 6'h05);
    rdc(IDX_MASK_ENABLE, 8'h03);
  endtask : t_mask

  task automatic t_adc;
    int c;
    wr(IDX_BRAKE_DATA, 8'h55);
    wr(IDX_IRQ_ENABLE, 8'h20);
    c = n_clr;
    adc_compare_event <= 1'b1;
    @(posedge pclk);
    adc_compare_event <= 1'b0;
    tick(3);
    check(generator_run, 1'b0);
    check(n_clr, c + 1);
    check(pwm_out, 6'h15 ^ 6'h05);
    check(brake_irq, 1'b1);
    rdc(IDX_BRAKE_DATA, 8'hD5);
    rdc(IDX_RUN_CONTROL, 8'h00);
    wr(IDX_BRAKE_DATA, 8'h55);
    tick(2);
    check(brake_irq, 1'b0);
    check(pwm_out, 6'h15 ^ 6'h05);
    wr(IDX_RUN_CONTROL, 8'h80);
    tick(3);
    check(pwm_out, ((6'h2A & ~6'h03) | 6'h01) ^ 6'h05);
  endtask : t_adc

  task automatic t_pin;
    wr(IDX_WAVE_CONFIG, 8'h00);
    pin.hold(20);
    tick(15);
    check(generator_run, 1'b1);
    wr(IDX_WAVE_CONFIG, 8'h08);
    pin.hold(5);
    tick(15);
    check(generator_run, 1'b1);
    pin.hold(20);
    tick(15);
    check(generator_run, 1'b0);
    check(pwm_out, 6'h15 ^ 6'h05);
    wr(IDX_BRAKE_DATA, 8'h15);
    wr(IDX_RUN_CONTROL, 8'h80);
    pin.hold(20);
    check(generator_run, 1'b1);
    tick(15);
    check(generator_run, 1'b0);
  endtask : t_pin

  task automatic t_ctrl;
    int c;
    wr(IDX_RUN_CONTROL, 8'hC0);
    tick(1);
    check(generator_run, 1'b1);
    rdc(IDX_RUN_CONTROL, 8'hC0);
    c = n_reload;
    period_complete <= 1'b1;
    @(posedge pclk);
    period_complete <= 1'b0;
    tick(3);
    check(n_reload, c + 1);
    // Software waits for the reload bit to drop before touching control again.
    do begin
      apb(1'b0, IDX_RUN_CONTROL, 8'h00);
    end while (rd[LOAD_BIT] !== 1'b0);
    rdc(IDX_RUN_CONTROL, 8'h80);
    c = n_clr;
    wr(IDX_RUN_CONTROL, 8'h90);
    tick(3);
    check(n_clr, c + 1);
    rdc(IDX_RUN_CONTROL, 8'h80);
  endtask : t_ctrl

  task automatic t_point;
    wr(IDX_POINT_CONFIG, 8'h22);
    wr(IDX_RUN_CONTROL, 8'h80);
    counter_center_point <= 1'b1;
    @(posedge pclk);
    counter_center_point <= 1'b0;
    tick(3);
    check(period_irq, 1'b0);
    wr(IDX_WAVE_CONFIG, 8'h18);
    for (int t = 0; t < 4; t++) begin
      gen_signal <= (t == 1) ? 6'h04 : 6'h00;
      wr(IDX_POINT_CONFIG, 8'(t * 16 + 2));
      wr(IDX_RUN_CONTROL, 8'h80);
      gen_signal <= (t == 0) ? 6'h04 : 6'h00;
      counter_center_point <= (t == 2);
      counter_end_point <= (t == 3);
      @(posedge pclk);
      counter_center_point <= 1'b0;
      counter_end_point <= 1'b0;
      tick(3);
      check(period_irq, 1'b1);
      rdc(IDX_RUN_CONTROL, 8'hA0);
    end
  endtask : t_point

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    gen_signal = '0;
    period_complete = 1'b0;
    counter_center_point = 1'b0;
    counter_end_point = 1'b0;
    adc_compare_event = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_adc();
    t_pin();
    t_ctrl();
    t_point();
    finish_test();
  end
endmodule : tb_pwm_output_protect_control
